// ---- design/cdl_regs.sv ----
// Purpose: cable diagnostic, reset/standby control and link status register bank
// Assumes: analog reflectometry engine and receiver live outside and report by pins
// Notes:   Avalon-MM slave, one wait state on every access
//
// Summary of operation
// - start bit launches measurement, self clears
// - done bit set when measurement finishes
// - fail bit set when measurement failed
// - hardware reset bit acts like reset pin
// - restart bit restarts circuitry, keeps registers
// - standby bit selects standby, resets to zero
// - live link status reported, unlatched
// - descrambler lock reported live
// - local receiver status reported live
// - remote receiver status reported live
// - fault detected flag in results
// - fault kind: short one, open zero
// - fault distance in 1.5 m steps
// - first and second peak locations
// - third and fourth peak locations
// - per-peak polarity, valid when location nonzero
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
module cdl_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // avalon-mm slave
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic      [1:0]  avs_response,
  output logic             avs_waitrequest,
  // measurement engine
  output logic             meas_start,
  input  wire logic        meas_end,
  input  wire logic        meas_fail,
  input  wire logic        meas_fault,
  input  wire logic        meas_short,
  input  wire logic [7:0]  meas_fault_dist,
  input  wire logic [31:0] meas_peak_loc,
  input  wire logic [3:0]  meas_peak_neg,
  // receiver state pins
  input  wire logic        link_up,
  input  wire logic        descr_lock,
  input  wire logic        local_rx_ok,
  input  wire logic        remote_rx_ok,
  // control outputs
  output logic             phy_reset_b,
  output logic             phy_restart,
  output logic             standby_en,
  output logic             irq
);
  // interrupt width is needed before the status declarations below
  localparam int IRQ_W = cdl_pkg::IRQ_W;
  logic [3:0]  rx_sync;
  logic [31:0] peak_loc_reg;
  logic [3:0]  peak_neg_reg;
  logic [7:0]  fault_dist_reg;
  logic        fault_reg;
  logic        short_reg;
  logic        done_reg;
  logic        fail_reg;
  logic [13:0] rc_rw_reg;
  logic        hw_reset_pend_reg;
  logic [4:0]  restart_cnt_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic        link_prev_reg;
  logic        access_reg;
  cdl_pkg::cdl_meas_e meas_state_reg;
  logic        soft_rst_b;
  logic        bus_take;
  logic        wr_hit;
  logic [9:0]  idx;
  logic [15:0] wdata;
  logic [15:0] rdata_next;
  logic        mapped;
  logic        meas_end_ev;
  logic        meas_launch;

  // receiver pins are asynchronous levels, so they pass the synchroniser
  cdl_sync #(.W(4)) u_rx_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .async_in ({link_up, descr_lock, local_rx_ok, remote_rx_ok}),
    .sync_out (rx_sync)
  );

  // internal reset: pin or the self-clearing hardware reset bit
  assign soft_rst_b = rst_b & ~hw_reset_pend_reg;

  // bus handshake: request is taken on the second cycle it stands
  assign bus_take = (avs_read | avs_write) & access_reg;
  assign idx      = avs_address[11:2];
  assign wdata    = {avs_byteenable[1] ? avs_writedata[15:8] : 8'h00,
                     avs_byteenable[0] ? avs_writedata[7:0]  : 8'h00};
  assign wr_hit   = avs_write & bus_take;

  function automatic logic lane_wr(input logic [3:0] be, input int bitpos);
    lane_wr = (bitpos >= 8) ? be[1] : be[0];
  endfunction : lane_wr

  function automatic logic wr_to(input logic [9:0] a, input logic [9:0] target);
    wr_to = (a == target);
  endfunction : wr_to

  assign meas_launch = wr_hit && wr_to(idx, cdl_pkg::IDX_MEASURE_CTRL)
                       && lane_wr(avs_byteenable, cdl_pkg::MC_START_BIT)
                       && avs_writedata[cdl_pkg::MC_START_BIT];
  assign meas_end_ev = (meas_state_reg == cdl_pkg::CDL_RUN) && meas_end;

  // wait state generator; one wait cycle gives registered read data
  always_ff @(posedge sys_clk)
  begin
    if (!soft_rst_b)
      access_reg <= 1'b0;
    else if (bus_take)
      access_reg <= 1'b0;
    else
      access_reg <= avs_read | avs_write;
  end

  // waitrequest kept in its own flop so the port comes straight from a register
  always_ff @(posedge sys_clk)
  begin
    if (!soft_rst_b)
      avs_waitrequest <= 1'b1;
    else if (bus_take)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~(avs_read | avs_write);
  end

  // measurement sequencer; start reads back as one while a run is active
  always_ff @(posedge sys_clk)
  begin
    if (!soft_rst_b)
    begin
      meas_state_reg <= cdl_pkg::CDL_IDLE;
      meas_start     <= 1'b0;
    end
    else
    begin
      meas_start <= meas_launch;
      case (meas_state_reg)
        cdl_pkg::CDL_IDLE, cdl_pkg::CDL_DONE:
          if (meas_launch)
            meas_state_reg <= cdl_pkg::CDL_RUN;
        cdl_pkg::CDL_RUN:
          if (meas_end)
            meas_state_reg <= cdl_pkg::CDL_DONE;
        default:
          meas_state_reg <= cdl_pkg::CDL_IDLE;
      endcase
    end
  end

  // outcome capture; relaunch wipes stale results first
  always_ff @(posedge sys_clk)
  begin
    if (!soft_rst_b)
    begin
      done_reg       <= 1'b0;
      fail_reg       <= 1'b0;
      fault_reg      <= 1'b0;
      short_reg      <= 1'b0;
      fault_dist_reg <= 8'h00;
      peak_loc_reg   <= 32'h0000_0000;
      peak_neg_reg   <= 4'h0;
    end
    else if (meas_launch)
    begin
      done_reg       <= 1'b0;
      fail_reg       <= 1'b0;
      fault_reg      <= 1'b0;
      short_reg      <= 1'b0;
      fault_dist_reg <= 8'h00;
      peak_loc_reg   <= 32'h0000_0000;
      peak_neg_reg   <= 4'h0;
    end
    else if (meas_end_ev)
    begin
      done_reg       <= 1'b1;
      fail_reg       <= meas_fail;
      fault_reg      <= meas_fault;
      short_reg      <= meas_fault & meas_short;
      fault_dist_reg <= meas_fault ? meas_fault_dist : 8'h00;
      peak_loc_reg   <= meas_peak_loc;
      // polarity held only where the peak location is nonzero
      for (int i = 0; i < 4; i++)
        peak_neg_reg[i] <= meas_peak_neg[i] & (|meas_peak_loc[8*i +: 8]);
    end
  end

  // reset control register; bits 15 and 14 are self clearing
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      hw_reset_pend_reg <= 1'b0;
    else if (hw_reset_pend_reg)
      hw_reset_pend_reg <= 1'b0;
    else
      hw_reset_pend_reg <= wr_hit && wr_to(idx, cdl_pkg::IDX_RESET_CTRL)
                           && avs_byteenable[1] && avs_writedata[cdl_pkg::RC_HW_RESET_BIT];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!soft_rst_b)
      rc_rw_reg <= 14'h0000;
    else if (wr_hit && wr_to(idx, cdl_pkg::IDX_RESET_CTRL))
    begin
      if (avs_byteenable[0])
        rc_rw_reg[7:0] <= wdata[7:0];
      if (avs_byteenable[1])
        rc_rw_reg[13:8] <= wdata[13:8];
    end
  end

  // restart pulse stretcher: registers survive, datapath sees a fixed pulse
  always_ff @(posedge sys_clk)
  begin
    if (!soft_rst_b)
      restart_cnt_reg <= 5'd0;
    else if (wr_hit && wr_to(idx, cdl_pkg::IDX_RESET_CTRL) && avs_byteenable[1]
             && avs_writedata[cdl_pkg::RC_RESTART_BIT])
      restart_cnt_reg <= 5'(cdl_pkg::RESTART_CYCLES);
    else if (restart_cnt_reg != 5'd0)
      restart_cnt_reg <= restart_cnt_reg - 5'd1;
  end

  // registered control outputs
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      phy_reset_b <= 1'b0;
      phy_restart <= 1'b0;
      standby_en  <= 1'b0;
    end
    else
    begin
      phy_reset_b <= ~hw_reset_pend_reg;
      phy_restart <= (restart_cnt_reg != 5'd0);
      standby_en  <= rc_rw_reg[cdl_pkg::RC_STANDBY_BIT];
    end
  end

  // sticky interrupt status, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk)
  begin
    if (!soft_rst_b)
    begin
      irq_stat_reg  <= '0;
      irq_mask_reg  <= '0;
      link_prev_reg <= 1'b0;
    end
    else
    begin
      link_prev_reg <= rx_sync[3];
      for (int i = 0; i < IRQ_W; i++)
      begin
        if (wr_hit && wr_to(idx, cdl_pkg::IDX_IRQ_STATUS) && avs_byteenable[0]
            && avs_writedata[i])
          irq_stat_reg[i] <= 1'b0;
      end
      if (meas_end_ev)
        irq_stat_reg[cdl_pkg::IRQ_DONE_BIT] <= 1'b1;
      if (meas_end_ev && meas_fail)
        irq_stat_reg[cdl_pkg::IRQ_FAIL_BIT] <= 1'b1;
      if (rx_sync[3] != link_prev_reg)
        irq_stat_reg[cdl_pkg::IRQ_LINK_BIT] <= 1'b1;
      if (wr_hit && wr_to(idx, cdl_pkg::IDX_IRQ_MASK) && avs_byteenable[0])
        irq_mask_reg <= avs_writedata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!soft_rst_b)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_reg & ~irq_mask_reg); // a set mask bit silences its source
  end

  // read multiplexer; reserved bits read their defaults
  always_comb
  begin
    rdata_next = cdl_pkg::RESET_VALUE;
    mapped     = 1'b1;
    case (idx)
      cdl_pkg::IDX_MEASURE_CTRL:
      begin
        rdata_next[cdl_pkg::MC_START_BIT] = (meas_state_reg == cdl_pkg::CDL_RUN);
        rdata_next[cdl_pkg::MC_DONE_BIT]  = done_reg;
        rdata_next[cdl_pkg::MC_FAIL_BIT]  = fail_reg;
      end
      cdl_pkg::IDX_RESET_CTRL:
        rdata_next = {2'b00, rc_rw_reg};
      cdl_pkg::IDX_LINK_STATE:
      begin
        rdata_next = cdl_pkg::LS_RSVD_VALUE;
        rdata_next[cdl_pkg::LS_LINK_BIT]   = rx_sync[3];
        rdata_next[cdl_pkg::LS_LOCK_BIT]   = rx_sync[2];
        rdata_next[cdl_pkg::LS_LOCAL_BIT]  = rx_sync[1];
        rdata_next[cdl_pkg::LS_REMOTE_BIT] = rx_sync[0];
      end
      cdl_pkg::IDX_FAULT_RES:
      begin
        rdata_next[cdl_pkg::FR_FAULT_BIT] = fault_reg;
        rdata_next[cdl_pkg::FR_SHORT_BIT] = short_reg;
        rdata_next[7:0] = fault_dist_reg;
      end
      cdl_pkg::IDX_PEAK_FIRST:
        rdata_next = peak_loc_reg[15:0];
      cdl_pkg::IDX_PEAK_SECOND:
        rdata_next = peak_loc_reg[31:16];
      cdl_pkg::IDX_PEAK_POL:
        rdata_next[cdl_pkg::PP_FIRST_BIT +: 4] = peak_neg_reg;
      cdl_pkg::IDX_IRQ_STATUS:
        rdata_next[IRQ_W-1:0] = irq_stat_reg;
      cdl_pkg::IDX_IRQ_MASK:
        rdata_next[IRQ_W-1:0] = irq_mask_reg;
      default:
        mapped = 1'b0;
    endcase
  end

  // read data and response registered at the answering edge
  always_ff @(posedge sys_clk)
  begin
    if (!soft_rst_b)
    begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'b00;
    end
    else if ((avs_read | avs_write) && !access_reg)
    begin
      avs_readdata <= avs_read ? {16'h0000, rdata_next} : 32'h0000_0000;
      avs_response <= mapped ? 2'b00 : 2'b11; // unmapped answers decode error
    end
  end
endmodule : cdl_regs

// ---- include/cdl_pkg.sv ----
// Purpose: shared constants for the cable diagnostic and link status register bank
// Assumes: 32-bit Avalon-MM word bus, registers hold 16-bit data in the low half
// Notes:   printed offsets are register indices; byte address is four times the index
package cdl_pkg;

  // register indices as printed
  localparam logic [9:0] IDX_MEASURE_CTRL = 10'h01E;
  localparam logic [9:0] IDX_RESET_CTRL   = 10'h01F;
  localparam logic [9:0] IDX_LINK_STATE   = 10'h133;
  localparam logic [9:0] IDX_FAULT_RES    = 10'h16B;
  localparam logic [9:0] IDX_PEAK_FIRST   = 10'h180;
  localparam logic [9:0] IDX_PEAK_SECOND  = 10'h181;
  localparam logic [9:0] IDX_PEAK_POL     = 10'h18A;
  // interrupt registers of our own
  localparam logic [9:0] IDX_IRQ_STATUS   = 10'h200;
  localparam logic [9:0] IDX_IRQ_MASK     = 10'h201;

  // measurement control fields
  localparam int MC_START_BIT = 15;
  localparam int MC_DONE_BIT  = 1;
  localparam int MC_FAIL_BIT  = 0;
  // reset control fields
  localparam int RC_HW_RESET_BIT = 15;
  localparam int RC_RESTART_BIT  = 14;
  localparam int RC_STANDBY_BIT  = 7;
  localparam logic [15:0] RC_RW_MASK = 16'h3FFF; // bits 13:0 plain read/write
  // link state fields
  localparam int LS_LINK_BIT  = 12;
  localparam int LS_LOCK_BIT  = 2;
  localparam int LS_LOCAL_BIT = 1;
  localparam int LS_REMOTE_BIT = 0;
  localparam logic [15:0] LS_RSVD_VALUE = 16'h05E0; // bits 11:3 read 0101_1110_0
  // fault result fields
  localparam int FR_FAULT_BIT = 9;
  localparam int FR_SHORT_BIT = 8;
  // polarity fields: peak n at bit 10+n
  localparam int PP_FIRST_BIT = 11;

  localparam logic [15:0] RESET_VALUE = 16'h0000;

  // interrupt status bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAIL_BIT = 1;
  localparam int IRQ_LINK_BIT = 2;
  localparam int IRQ_W        = 3;

  // restart pulse length
  localparam int RESTART_CYCLES = 16;

  typedef enum logic [1:0] {
    CDL_IDLE = 2'b00,
    CDL_RUN  = 2'b01,
    CDL_DONE = 2'b11
  } cdl_meas_e;

endpackage : cdl_pkg

// ---- design/cdl_sync.sv ----
// Purpose: two flip-flop synchroniser for a bus of level inputs
// Assumes: inputs are quasi-static levels from outside the clock domain
// Notes:   the first stage is read only by the second stage
`timescale 1ns/1ps
module cdl_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1_reg;

  // double register against metastability
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end
    else
    begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end
endmodule : cdl_sync

// ---- bench/cdl_regs_sva.sv ----
// Purpose: port-level checks for the cable diagnostic register bank
// Assumes: one clock, synchronous active-low reset
// Notes:   cycle bounds follow the one-wait-state bus contract
`timescale 1ns/1ps
module cdl_regs_sva (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic [1:0]  avs_response,
  input wire logic        avs_waitrequest,
  input wire logic        meas_start,
  input wire logic        phy_reset_b,
  input wire logic        phy_restart,
  input wire logic        standby_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [5:0] hi_cnt;
  // restart length counter; a short pulse would leave circuitry half restarted
  always_ff @(posedge sys_clk)
    hi_cnt <= phy_restart ? hi_cnt + 6'h01 : 6'h00;
  chk_start_once: assert property (meas_start |=> !meas_start)
    else $error("start pulse too long");
  chk_start_cause: assert property
    (meas_start |-> $past(avs_write) || $past(avs_write, 2))
    else $error("start without write");
  chk_restart_len: assert property ($fell(phy_restart) |-> hi_cnt == 6'h10)
    else $error("restart pulse not 16 cycles");
  chk_restart_cause: assert property
    ($rose(phy_restart) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("restart without write");
  chk_reset_short: assert property (!phy_reset_b && $past(rst_b) |=> phy_reset_b)
    else $error("transceiver reset too long");
  chk_standby_cause: assert property
    ($changed(standby_en) |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("standby moved without write");
  chk_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  chk_unmapped_zero: assert property
    (!avs_waitrequest && avs_read && avs_response == 2'h3 |-> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  cover property (meas_start);
  cover property ($fell(phy_restart));
  cover property (!avs_waitrequest && avs_response == 2'h3);
endmodule : cdl_regs_sva
bind cdl_regs cdl_regs_sva i_cdl_regs_sva (.sys_clk, .rst_b, .avs_read, .avs_write,
  .avs_readdata, .avs_response, .avs_waitrequest, .meas_start, .phy_reset_b, .phy_restart,
  .standby_en);

// ---- bench/cdl_engine_model.sv ----
// Purpose: behavioural reflectometry engine behind the register bank
// Assumes: engine shares the register bank clock
// Notes:   result lines carry inverted values outside the finishing cycle
`timescale 1ns/1ps
module cdl_engine_model #(
  parameter int RUN_CYCLES = 20
) (
  input  wire logic        sys_clk,
  input  wire logic        meas_start,
  input  wire logic        fail_mode,
  output logic             meas_end,
  output logic             meas_fail,
  output logic             meas_fault,
  output logic             meas_short,
  output logic      [7:0]  meas_fault_dist,
  output logic      [31:0] meas_peak_loc,
  output logic      [3:0]  meas_peak_neg
);
  int run_cnt = 0;
  initial meas_end = 1'b0;
  // counts out a run; a start while running is ignored
  always @(posedge sys_clk)
  begin
    meas_end <= (run_cnt == 1);
    if (meas_start && run_cnt == 0)
      run_cnt <= RUN_CYCLES;
    else if (run_cnt != 0)
      run_cnt <= run_cnt - 1;
  end
  // fourth peak absent so its polarity must read clear
  assign meas_fail       = meas_end ? fail_mode : !fail_mode;
  assign meas_fault      = meas_end;
  assign meas_short      = meas_end;
  assign meas_fault_dist = meas_end ? 8'h2A : 8'hD5;
  assign meas_peak_loc   = meas_end ? 32'h000D0A07 : 32'hFFF2F5F8;
  assign meas_peak_neg   = meas_end ? 4'hF : 4'h0;
endmodule : cdl_engine_model

// ---- bench/cdl_regs_bench.sv ----
// Purpose: self-checking bench for the cable diagnostic register bank
// Assumes: avalon master holds each request until waitrequest is low
// Notes:   expected link word carries the fixed reserved pattern 0x05E0
`timescale 1ns/1ps
module cdl_regs_bench;
  localparam logic [9:0] MC = cdl_pkg::IDX_MEASURE_CTRL;
  localparam logic [9:0] RC = cdl_pkg::IDX_RESET_CTRL;
  localparam logic [9:0] LS = cdl_pkg::IDX_LINK_STATE;
  localparam logic [9:0] FR = cdl_pkg::IDX_FAULT_RES;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic [1:0]  avs_response;
  logic [3:0]  link_v = 4'h0;
  logic        fail_mode = 1'b0;
  logic        avs_waitrequest, meas_start, meas_end, meas_fail, meas_fault, meas_short;
  logic [7:0]  meas_fault_dist;
  logic [31:0] meas_peak_loc;
  logic [3:0]  meas_peak_neg;
  logic        phy_reset_b, phy_restart, standby_en, irq;
  logic [15:0] rd;
  logic [1:0]  rsp;
  int          err_total = 0;
  int          checks_done = 0;
  // bench clock, 25 ns period
  always #12.5 sys_clk = ~sys_clk;
  cdl_regs i_cdl_regs (.sys_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'h3), .avs_readdata, .avs_response, .avs_waitrequest, .meas_start,
    .meas_end, .meas_fail, .meas_fault, .meas_short, .meas_fault_dist, .meas_peak_loc,
    .meas_peak_neg, .link_up(link_v[3]), .descr_lock(link_v[2]), .local_rx_ok(link_v[1]),
    .remote_rx_ok(link_v[0]), .phy_reset_b, .phy_restart, .standby_en, .irq);
  cdl_engine_model i_cdl_engine_model (.sys_clk, .meas_start, .fail_mode, .meas_end,
    .meas_fail, .meas_fault, .meas_short, .meas_fault_dist, .meas_peak_loc, .meas_peak_neg);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  // one access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [15:0] wd);
    @(posedge sys_clk);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {16'h0000, wd};
    avs_read      <= !wr;
    avs_write     <= wr;
    // no local limit: only the watchdog ends a hung access
    do
    begin
      @(posedge sys_clk);
    end
    while (avs_waitrequest !== 1'b0);
    rd  = avs_readdata[15:0];
    rsp = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rdc(input logic [9:0] idx, input logic [15:0] exp, input string what);
    bus(1'b0, idx, 16'h0000);
    check(rd, exp, what);
  endtask : rdc
  // polls until done; a hung engine ends after thirty reads
  task automatic poll_done();
    rd = 16'h0000;
    for (int k = 0; k < 30 && rd[1] !== 1'b1; k++)
      bus(1'b0, MC, 16'h0000);
  endtask : poll_done
  task automatic t_defaults();
    rdc(MC, 16'h0000, "measure ctrl");
    rdc(RC, 16'h0000, "reset ctrl");
    rdc(LS, 16'h05E0, "link word");
    rdc(FR, 16'h0000, "fault word");
    rdc(cdl_pkg::IDX_PEAK_FIRST, 16'h0000, "peaks 1/2");
    rdc(cdl_pkg::IDX_PEAK_SECOND, 16'h0000, "peaks 3/4");
    bus(1'b0, 10'h0FF, 16'h0000);
    check({14'h0000, rsp}, 16'h0003, "unmapped");
    $display("defaults test done");
  endtask : t_defaults
  task automatic t_link();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      link_v <= 4'h1 << i;
      repeat (4) @(posedge sys_clk);
      rdc(LS, 16'h05E0 | (i == 3 ? 16'h1000 : 16'h0001 << i), "link bit");
    end
    link_v <= 4'h0;
    bus(1'b1, LS, 16'hFFFF);
    repeat (4) @(posedge sys_clk);
    rdc(LS, 16'h05E0, "link word write");
    $display("link test done");
  endtask : t_link
  task automatic t_measure();
    bus(1'b1, cdl_pkg::IDX_IRQ_MASK, 16'h0000);
    bus(1'b1, cdl_pkg::IDX_IRQ_STATUS, 16'h0007);
    bus(1'b1, MC, 16'h8000);
    rdc(MC, 16'h8000, "running");
    poll_done();
    check(rd, 16'h0002, "done");
    rdc(FR, 16'h032A, "fault word");
    rdc(cdl_pkg::IDX_PEAK_FIRST, 16'h0A07, "peaks 1/2");
    rdc(cdl_pkg::IDX_PEAK_SECOND, 16'h000D, "peaks 3/4");
    rdc(cdl_pkg::IDX_PEAK_POL, 16'h3800, "polarity");
    bus(1'b1, MC, 16'h0001);
    bus(1'b1, FR, 16'hFFFF);
    rdc(MC, 16'h0002, "ro control");
    rdc(FR, 16'h032A, "ro results");
    check({15'h0000, irq}, 16'h0001, "irq raised");
    bus(1'b1, cdl_pkg::IDX_IRQ_MASK, 16'h0001);
    repeat (2) @(posedge sys_clk);
    check({15'h0000, irq}, 16'h0000, "irq masked");
    bus(1'b1, cdl_pkg::IDX_IRQ_MASK, 16'h0000);
    bus(1'b1, cdl_pkg::IDX_IRQ_STATUS, 16'h0001);
    repeat (2) @(posedge sys_clk);
    check({15'h0000, irq}, 16'h0000, "irq cleared");
    @(posedge sys_clk);
    fail_mode <= 1'b1;
    bus(1'b1, MC, 16'h8000);
    rdc(FR, 16'h0000, "stale results");
    poll_done();
    check(rd & 16'h0001, 16'h0001, "fail flag");
    $display("measure test done");
  endtask : t_measure
  task automatic t_reset_ctrl();
    bus(1'b1, RC, 16'h0080);
    repeat (2) @(posedge sys_clk);
    check({15'h0000, standby_en}, 16'h0001, "standby on");
    bus(1'b1, RC, 16'h4080);
    repeat (2) @(posedge sys_clk);
    check({15'h0000, phy_restart}, 16'h0001, "restart on");
    repeat (20) @(posedge sys_clk);
    check({15'h0000, phy_restart}, 16'h0000, "restart off");
    rdc(RC, 16'h0080, "restart kept regs");
    // standby rewritten as one, so only the reset itself can clear it
    bus(1'b1, RC, 16'h8080);
    repeat (3) @(posedge sys_clk);
    check({15'h0000, standby_en}, 16'h0000, "standby reset");
    rdc(RC, 16'h0000, "reset ctrl");
    rdc(MC, 16'h0000, "measure ctrl");
    $display("reset control test done");
  endtask : t_reset_ctrl
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  // main sequence after a three-cycle reset
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_defaults();
    t_link();
    t_measure();
    t_reset_ctrl();
    close_out();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    close_out();
  end
endmodule : cdl_regs_bench
